// file: core/ebs_core.v
// External bus strobes, wait states, boot select and watchdog reset pulse
`include "ebs_regs.vh"
module ebs_core #(
	parameter AW = 16
) (
	input  wire          clock_i,
	input  wire          rstn_i,
	input  wire          req_i,
	input  wire [1:0]    req_space_i,
	input  wire          req_write_i,
	input  wire          req_global_i,
	input  wire [AW-1:0] req_addr_i,
	input  wire [2:0]    wait_state_config_i,
	input  wire          ready_i,
	input  wire          external_interface_enable_i,
	input  wire          emulation_float_n_i,
	input  wire          power_down_i,
	input  wire          bus_visibility_mode_set_i,
	input  wire          bus_visibility_mode_clr_i,
	input  wire          boot_source_select_i,
	input  wire          watchdog_overflow_i,
	output reg           done_o,
	output reg           illegal_addr_o,
	output reg  [AW-1:0] addr_o,
	output reg           program_space_select_n_o,
	output reg           data_space_select_n_o,
	output reg           io_space_select_n_o,
	output reg           space_select_oe_n_o,
	output reg           write_strobe_n_o,
	output reg           write_strobe_oe_n_o,
	output reg           read_strobe_n_o,
	output reg           read_strobe_oe_n_o,
	output reg           transfer_direction_o,
	output reg           transfer_direction_oe_n_o,
	output reg           external_access_strobe_n_o,
	output reg           external_access_strobe_oe_n_o,
	output reg           global_memory_request_n_o,
	output reg           global_memory_request_oe_n_o,
	output reg           data_bus_oe_n_o,
	output reg           visibility_output_enable_n_o,
	output reg           clock_output_o,
	output reg           visibility_clock_o,
	output reg           bus_visibility_mode_o,
	output reg           boot_external_o,
	output reg  [AW-1:0] fetch_addr_o,
	output reg           system_reset_n_o,
	output reg           system_reset_oe_n_o
);

// ----------------------------------------
// State
// ----------------------------------------
reg [1:0]             state;
reg [`EBS_WAIT_W-1:0] wcnt;
reg [1:0]             space;
reg                   wr;
reg                   glob;
reg                   boot_pending;
reg [3:0]             rst_cnt;
reg                   vis;

wire float_all = ~emulation_float_n_i;
wire float_pd  = float_all | power_down_i;
wire active    = (state != `EBS_ST_IDLE);

function [2:0] ebs_dec;
	input [1:0] s;
	begin
		case (s)
			`EBS_SPACE_PROG: ebs_dec = `EBS_SEL_PROG;
			`EBS_SPACE_DATA: ebs_dec = `EBS_SEL_DATA;
			`EBS_SPACE_IO:   ebs_dec = `EBS_SEL_IO;
			default:         ebs_dec = `EBS_SEL_NONE;
		endcase
	end
endfunction

// ----------------------------------------
// Access sequencer
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		state          <= `EBS_ST_IDLE;
		wcnt           <= {`EBS_WAIT_W{1'b0}};
		space          <= `EBS_SPACE_PROG;
		wr             <= 1'b0;
		glob           <= 1'b0;
		addr_o         <= {AW{1'b0}};
		done_o         <= 1'b0;
		illegal_addr_o <= 1'b0;
	end else begin
		done_o         <= 1'b0;
		illegal_addr_o <= 1'b0;
		case (state)
			`EBS_ST_IDLE: begin
				if (req_i && !external_interface_enable_i) begin
					illegal_addr_o <= 1'b1;
					done_o         <= 1'b1;
				end else if (req_i) begin
					space  <= req_space_i;
					wr     <= req_write_i;
					glob   <= req_global_i & (req_space_i == `EBS_SPACE_DATA);
					addr_o <= req_addr_i;
					wcnt   <= wait_state_config_i;
					state  <= (wait_state_config_i == {`EBS_WAIT_W{1'b0}}) ?
						`EBS_ST_READY : `EBS_ST_WAIT;
				end
			end
			`EBS_ST_WAIT: begin
				if (wcnt > 3'h1)
					wcnt <= wcnt - 3'h1;
				else
					state <= `EBS_ST_READY;
			end
			`EBS_ST_READY: begin
				// Zero wait states skip ready entirely
				if (wait_state_config_i == {`EBS_WAIT_W{1'b0}} || ready_i) begin
					state  <= `EBS_ST_IDLE;
					done_o <= 1'b1;
				end
			end
			default: state <= `EBS_ST_IDLE;
		endcase
	end
end

// ----------------------------------------
// Pin helpers
// ----------------------------------------
wire       wr_cycle     = active & wr;
wire       rd_cycle     = active & ~wr;
wire [2:0] next_sel     = active ? ebs_dec(space) : `EBS_SEL_NONE;
wire       pulse_start  = watchdog_overflow_i && (rst_cnt == `EBS_RST_CNT_IDLE);
wire       next_rst_low = pulse_start || (rst_cnt > `EBS_RST_CNT_LAST);

// ----------------------------------------
// Space selects
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		program_space_select_n_o <= 1'b1;
		data_space_select_n_o    <= 1'b1;
		io_space_select_n_o      <= 1'b1;
	end else begin
		program_space_select_n_o <= next_sel[0];
		data_space_select_n_o    <= next_sel[1];
		io_space_select_n_o      <= next_sel[2];
	end
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		space_select_oe_n_o <= 1'b1;
	else
		space_select_oe_n_o <= float_pd;
end

// ----------------------------------------
// Write strobe
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		write_strobe_n_o <= 1'b1;
	else
		write_strobe_n_o <= ~wr_cycle;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		write_strobe_oe_n_o <= 1'b0;
	else
		write_strobe_oe_n_o <= float_all;
end

// ----------------------------------------
// Read strobe
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		read_strobe_n_o <= 1'b1;
	else
		read_strobe_n_o <= ~rd_cycle;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		read_strobe_oe_n_o <= 1'b0;
	else
		read_strobe_oe_n_o <= float_all;
end

// ----------------------------------------
// Transfer direction
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		transfer_direction_o <= 1'b1;
	else
		transfer_direction_o <= ~wr_cycle;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		transfer_direction_oe_n_o <= 1'b0;
	else
		transfer_direction_oe_n_o <= float_pd;
end

// ----------------------------------------
// Access strobe
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		external_access_strobe_n_o <= 1'b1;
	else
		external_access_strobe_n_o <= ~active;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		external_access_strobe_oe_n_o <= 1'b0;
	else
		external_access_strobe_oe_n_o <= float_pd;
end

// ----------------------------------------
// Global memory request
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		global_memory_request_n_o <= 1'b1;
	else
		global_memory_request_n_o <= ~(active & glob);
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		global_memory_request_oe_n_o <= 1'b1;
	else
		global_memory_request_oe_n_o <= float_pd;
end

// ----------------------------------------
// Data bus direction, visibility enable
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		data_bus_oe_n_o <= 1'b1;
	else
		data_bus_oe_n_o <= ~(wr_cycle | vis);
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		visibility_output_enable_n_o <= 1'b1;
	else
		visibility_output_enable_n_o <= ~(vis & ~rd_cycle);
end

// ----------------------------------------
// Clocks
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		clock_output_o <= 1'b0;
	else
		clock_output_o <= ~clock_output_o;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		visibility_clock_o <= 1'b0;
	else
		visibility_clock_o <= ~clock_output_o;
end

// ----------------------------------------
// Visibility mode
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		vis <= 1'b1;
	else if (bus_visibility_mode_clr_i)
		vis <= 1'b0;
	else if (bus_visibility_mode_set_i)
		vis <= 1'b1;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		bus_visibility_mode_o <= 1'b1;
	else
		bus_visibility_mode_o <= vis;
end

// ----------------------------------------
// Boot source
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		boot_pending    <= 1'b1;
		boot_external_o <= 1'b0;
		fetch_addr_o    <= `EBS_BOOT_ADDR;
	end else begin
		boot_pending <= 1'b0;
		if (boot_pending) begin
			boot_external_o <= boot_source_select_i;
			fetch_addr_o    <= `EBS_BOOT_ADDR;
		end
	end
end

// ----------------------------------------
// Watchdog reset pulse
// ----------------------------------------
always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		rst_cnt <= `EBS_RST_CNT_IDLE;
	else if (pulse_start)
		rst_cnt <= `EBS_RST_PULSE_CYC;
	else if (rst_cnt != `EBS_RST_CNT_IDLE)
		rst_cnt <= rst_cnt - 4'h1;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		system_reset_n_o <= 1'b1;
	else
		system_reset_n_o <= ~next_rst_low;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i)
		system_reset_oe_n_o <= 1'b1;
	else
		system_reset_oe_n_o <= ~next_rst_low;
end

endmodule

// file: core/ebs_regs.vh
// Constants of the external bus strobe and boot block
`ifndef EBS_REGS_VH
`define EBS_REGS_VH
`define EBS_RST_PULSE_CYC   4'h8
`define EBS_WAIT_W          3
`define EBS_SPACE_PROG      2'h0
`define EBS_SPACE_DATA      2'h1
`define EBS_SPACE_IO        2'h2
`define EBS_BOOT_ADDR       16'h0000
`define EBS_ST_IDLE         2'h0
`define EBS_ST_WAIT         2'h1
`define EBS_ST_READY        2'h2
`define EBS_SEL_NONE        3'h7
`define EBS_SEL_PROG        3'h6
`define EBS_SEL_DATA        3'h5
`define EBS_SEL_IO          3'h3
`define EBS_RST_CNT_IDLE    4'h0
`define EBS_RST_CNT_LAST    4'h1
`endif

// file: dv/ebs_core_asserts.sv
// Concurrent checks of the external bus strobe block
module ebs_core_asserts (
	input wire logic       clock_i,
	input wire logic       rstn_i,
	input wire logic       done_o,
	input wire logic       ready_i,
	input wire logic [2:0] wait_state_config_i,
	input wire logic       emulation_float_n_i,
	input wire logic       program_space_select_n_o,
	input wire logic       data_space_select_n_o,
	input wire logic       io_space_select_n_o,
	input wire logic       space_select_oe_n_o,
	input wire logic       write_strobe_n_o,
	input wire logic       read_strobe_n_o,
	input wire logic       transfer_direction_o,
	input wire logic       external_access_strobe_n_o,
	input wire logic       system_reset_n_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	wire logic [2:0] sel = {program_space_select_n_o, data_space_select_n_o, io_space_select_n_o};
	sequence s_held;
		(!external_access_strobe_n_o && !done_o) ##1 !external_access_strobe_n_o;
	endsequence
	sequence s_pulse;
		!system_reset_n_o [*8] ##1 system_reset_n_o;
	endsequence
	property p_one_sel;
		$countones(sel) >= 2;
	endproperty
	property p_sel_idle;
		external_access_strobe_n_o |-> sel == 3'h7;
	endproperty
	property p_wr_dir;
		!write_strobe_n_o |-> !transfer_direction_o && !external_access_strobe_n_o;
	endproperty
	property p_rd_dir;
		!read_strobe_n_o |-> transfer_direction_o && !external_access_strobe_n_o;
	endproperty
	property p_float;
		!emulation_float_n_i |=> space_select_oe_n_o;
	endproperty
	property p_stable;
		s_held |-> $stable(transfer_direction_o) && $stable(sel);
	endproperty
	property p_ready;
		!external_access_strobe_n_o && !ready_i && wait_state_config_i != 3'h0 |=> !done_o;
	endproperty
	property p_pulse;
		$fell(system_reset_n_o) |-> s_pulse;
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("two selects low");
	a_sel_idle: assert property (p_sel_idle) else $error("select outside access");
	a_wr_dir: assert property (p_wr_dir) else $error("write direction");
	a_rd_dir: assert property (p_rd_dir) else $error("read direction");
	a_float: assert property (p_float) else $error("select not floated");
	a_stable: assert property (p_stable) else $error("controls moved");
	a_ready: assert property (p_ready) else $error("done while not ready");
	a_pulse: assert property (p_pulse) else $error("reset pulse width");
endmodule
bind ebs_core ebs_core_asserts u_ebs_core_asserts (.*);

// file: dv/ebs_core_tb_top.sv
// Testbench of the external bus strobe block
module ebs_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rstn_i, req_i, req_write_i, req_global_i, ready_i, external_interface_enable_i;
	logic emulation_float_n_i, power_down_i, bus_visibility_mode_set_i, bus_visibility_mode_clr_i;
	logic boot_source_select_i, watchdog_overflow_i, done_o, illegal_addr_o, data_space_select_n_o;
	logic program_space_select_n_o, io_space_select_n_o, space_select_oe_n_o, write_strobe_n_o;
	logic write_strobe_oe_n_o, read_strobe_n_o, read_strobe_oe_n_o, transfer_direction_o;
	logic transfer_direction_oe_n_o, external_access_strobe_n_o, external_access_strobe_oe_n_o;
	logic global_memory_request_n_o, global_memory_request_oe_n_o, data_bus_oe_n_o;
	logic visibility_output_enable_n_o, clock_output_o, visibility_clock_o, bus_visibility_mode_o;
	logic boot_external_o, system_reset_n_o, system_reset_oe_n_o;
	logic [1:0] req_space_i;
	logic [2:0] wait_state_config_i;
	logic [3:0] stall;
	logic [15:0] req_addr_i, addr_o, fetch_addr_o;
	int err_count = 0, num_checks = 0, cyc = 0, n;
	ebs_core u_ebs_core (.*);
	ebs_mem_model u_ebs_mem_model (.clock_i(clock_i), .strobe_n_i(external_access_strobe_n_o),
		.stall_i(stall), .ready_o(ready_i));
	initial begin
		clock_i = 0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			conclude;
		end
	end
	task automatic step;
		@(posedge clock_i);
		#1;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic acc(input logic [1:0] sp, input logic wr);
		logic [5:0] seen;
		seen = 6'h3F;
		n = 0;
		{req_space_i, req_write_i, req_i} = {sp, wr, 1'b1};
		step;
		req_i = 1'b0;
		while (n < 40) begin
			if (external_access_strobe_n_o === 1'b0)
				seen &= {io_space_select_n_o, data_space_select_n_o, program_space_select_n_o,
					write_strobe_n_o, read_strobe_n_o, global_memory_request_n_o};
			if (done_o === 1'b1)
				break;
			step;
			n++;
		end
		chk(seen, {~(3'h1 << sp), ~wr, wr, sp != 2'h1});
		chk(addr_o, req_addr_i);
	endtask
	initial begin
		{req_i, req_write_i, power_down_i, bus_visibility_mode_set_i, watchdog_overflow_i} = 0;
		{rstn_i, bus_visibility_mode_clr_i, req_space_i, wait_state_config_i} = 0;
		{req_global_i, external_interface_enable_i, emulation_float_n_i} = 3'h7;
		{boot_source_select_i, stall, req_addr_i} = {1'b1, 4'h3, 16'h1234};
		repeat (4) @(posedge clock_i);
		#1 rstn_i = 1'b1;
		step;
		chk({boot_external_o, fetch_addr_o}, 17'h10000);
		chk({bus_visibility_mode_o, data_bus_oe_n_o, visibility_output_enable_n_o}, 3'h4);
		bus_visibility_mode_clr_i = 1'b1;
		step;
		bus_visibility_mode_clr_i = 1'b0;
		step;
		chk({bus_visibility_mode_o, visibility_output_enable_n_o}, 2'h1);
		n = clock_output_o;
		step;
		chk({clock_output_o, visibility_clock_o}, {~n[0], ~n[0]});
		wait_state_config_i = 3'h1;
		for (int s = 0; s < 6; s++) begin
			acc(s[2:1], s[0]);
			chk(n >= 4, 1'b1);
		end
		wait_state_config_i = 3'h0;
		acc(2'h1, 1'b1);
		chk(n, 1);
		external_interface_enable_i = 1'b0;
		req_i = 1'b1;
		step;
		req_i = 1'b0;
		chk({illegal_addr_o, done_o}, 2'h3);
		step;
		{external_interface_enable_i, emulation_float_n_i} = 2'h2;
		repeat (2) step;
		chk({space_select_oe_n_o, write_strobe_oe_n_o, read_strobe_oe_n_o,
			transfer_direction_oe_n_o, external_access_strobe_oe_n_o}, 5'h1F);
		{emulation_float_n_i, power_down_i} = 2'h3;
		repeat (2) step;
		chk({space_select_oe_n_o, transfer_direction_oe_n_o, external_access_strobe_oe_n_o,
			global_memory_request_oe_n_o}, 4'hF);
		{power_down_i, watchdog_overflow_i} = 2'h1;
		step;
		watchdog_overflow_i = 1'b0;
		n = !system_reset_n_o;
		repeat (15) begin
			step;
			n += !system_reset_n_o;
		end
		chk(n, 8);
		chk({system_reset_n_o, system_reset_oe_n_o}, 2'h3);
		conclude;
	end
endmodule

// file: dv/ebs_mem_model.sv
// Slow external memory answering with ready
module ebs_mem_model (
	input  wire logic       clock_i,
	input  wire logic       strobe_n_i,
	input  wire logic [3:0] stall_i,
	output wire logic       ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	always @(posedge clock_i) begin
		cnt <= strobe_n_i ? 4'h0 : cnt + 4'h1;
	end
	// Not ready for stall_i cycles of each access
	assign ready_o = strobe_n_i || cnt >= stall_i;
endmodule
